//--- rtl/dcc_regs.svh
// Constants for the DDR4 command and control input front end.
// Assumes a single reference clock that stands for the true clock's rising
// crossing; figures below are counts, bit positions or codes, save the clock limit in MHz.
`ifndef DCC_REGS_SVH
`define DCC_REGS_SVH
`define DCC_NUM_BANKS       8
`define DCC_ADDR_W          17
`define DCC_AUTO_CLOSE_BIT  10
`define DCC_CHOP_BIT        12
`define DCC_CMD_HI          16
`define DCC_CMD_LO          14
`define DCC_BL_EIGHT        2'h0
`define DCC_BL_CHOP         2'h1
`define DCC_BL_OTF          2'h2
`define DCC_ADD_ZERO        2'h0
`define DCC_ADD_RD1         2'h1
`define DCC_ADD_RD2         2'h2
`define DCC_BURST_FOUR      4'h4
`define DCC_BURST_EIGHT     4'h8
`define DCC_PRE_ONE         2'h1
`define DCC_PRE_TWO         2'h2
`define DCC_MAX_CLK_MHZ     1600
`define DCC_SYNC_W          24
// Synchroniser reset levels: clock-gate, chip select and row-open idle high.
`define DCC_PIN_RST         24'hE00000
`endif

//--- rtl/dcc_pkg.sv
// Types shared by the command front end modules.
// Assumes nothing of its surroundings.
package dcc_pkg;
   typedef enum logic [3:0] {
      CMD_NONE, CMD_MRS, CMD_REF, CMD_PRE, CMD_RFU,
      CMD_WR, CMD_RD, CMD_ZQ, CMD_NOP, CMD_ACT
   } dcc_cmd_t;

   typedef enum logic [1:0] {
      PS_RUN, PS_PRE_PD, PS_ACT_PD, PS_SELF_REF
   } dcc_pwr_t;

   // Bank group is the upper index bit, bank address the lower two.
   function automatic logic [2:0] dcc_bank_idx(input logic       bg,
                                               input logic [1:0] ba);
      dcc_bank_idx = {bg, ba};
   endfunction : dcc_bank_idx
endpackage : dcc_pkg

//--- rtl/dcc_cmd_if.sv
// Decoded command handed from the decoder to the control core.
// Assumes both ends run on the same reference clock.
`timescale 1ns/1ps
interface dcc_cmd_if;
   import dcc_pkg::*;
   logic            valid;
   dcc_cmd_t        kind;
   logic [2:0]      bank;
   logic [16:0]     row;
   logic            auto_close;
   logic            chop_n;
   modport dec  (output valid, kind, bank, row, auto_close, chop_n);
   modport core (input  valid, kind, bank, row, auto_close, chop_n);
endinterface : dcc_cmd_if

//--- rtl/dcc_sync.sv
// Two-stage synchroniser for a vector of pin inputs.
// Assumes each bit is independent; no word coherence is promised.
`timescale 1ns/1ps
module dcc_sync #(
   parameter int           W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         ref_clk_i,
   input  wire logic         rst_n_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta_q;

   always_ff @(posedge ref_clk_i) begin
      // Reset to the idle levels of the pins, so that a release of reset
      // never shows the logic a false clock-gate or command edge.
      if (!rst_n_i) begin
         meta_q <= RST_VAL;
         q_o    <= RST_VAL;
      end else begin
         meta_q <= d_i;
         q_o    <= meta_q;
      end
   end
endmodule : dcc_sync

//--- rtl/dcc_cmd_decode.sv
// Command decoder for sampled chip-select, row-open and command pins.
// Assumes its inputs are already synchronised and that en_i is registered.
`timescale 1ns/1ps
`include "dcc_regs.svh"
module dcc_cmd_decode (
   input  wire logic        en_i,
   input  wire logic        cs_n_i,
   input  wire logic        act_n_i,
   input  wire logic [16:0] addr_i,
   input  wire logic        bg_i,
   input  wire logic [1:0]  ba_i,
   dcc_cmd_if.dec           cmd
);
   import dcc_pkg::*;

   always_comb begin
      cmd.kind = CMD_NONE;
      if (en_i && !cs_n_i) begin
         if (!act_n_i) begin
            cmd.kind = CMD_ACT;
         end else begin
            unique case (addr_i[`DCC_CMD_HI:`DCC_CMD_LO])
               3'h0: cmd.kind = CMD_MRS;
               3'h1: cmd.kind = CMD_REF;
               3'h2: cmd.kind = CMD_PRE;
               3'h3: cmd.kind = CMD_RFU;
               3'h4: cmd.kind = CMD_WR;
               3'h5: cmd.kind = CMD_RD;
               3'h6: cmd.kind = CMD_ZQ;
               3'h7: cmd.kind = CMD_NOP;
            endcase
         end
      end
      cmd.valid      = (cmd.kind != CMD_NONE) && (cmd.kind != CMD_NOP);
      cmd.bank       = dcc_bank_idx(bg_i, ba_i);
      cmd.row        = addr_i;
      cmd.auto_close = addr_i[`DCC_AUTO_CLOSE_BIT];
      cmd.chop_n     = addr_i[`DCC_CHOP_BIT];
   end
endmodule : dcc_cmd_decode

//--- rtl/dcc_cmd_ctrl.sv
// Command and control input front end of a 16-bit DDR4 memory device.
// Assumes ref_clk_i is the true clock; its rising edge is the crossing at
// which the complementary clock falls, so no separate complement port exists.
`timescale 1ns/1ps
`include "dcc_regs.svh"
module dcc_cmd_ctrl (
   input  wire logic              ref_clk_i,
   input  wire logic              rst_n_i,
   input  wire logic              cke_i,
   input  wire logic              cs_n_i,
   input  wire logic              row_open_cmd_n_i,
   input  wire logic              on_die_term_ctrl_i,
   input  wire logic [16:0]       addr_i,
   input  wire logic              bg_i,
   input  wire logic [1:0]        ba_i,
   input  wire logic              termination_default_dis_i,
   input  wire logic [1:0]        added_delay_setting_i,
   input  wire logic [5:0]        read_delay_setting_i,
   input  wire logic [1:0]        burst_mode_i,
   input  wire logic              burst_interleave_i,
   input  wire logic              preamble_two_i,
   output logic                   int_clk_en_o,
   output logic                   out_drv_en_o,
   output logic                   clk_buf_en_o,
   output logic                   term_buf_en_o,
   output logic                   cke_buf_en_o,
   output logic                   cmd_buf_en_o,
   output dcc_pkg::dcc_pwr_t      pwr_state_o,
   output logic                   term_on_o,
   output logic                   cmd_valid_o,
   output dcc_pkg::dcc_cmd_t      cmd_kind_o,
   output logic [2:0]             cmd_bank_o,
   output logic [16:0]            row_addr_o,
   output logic                   auto_close_o,
   output logic                   close_all_o,
   output logic [3:0]             burst_len_o,
   output logic                   burst_interleave_o,
   output logic [7:0]             bank_open_o,
   output logic [5:0]             added_delay_o,
   output logic [1:0]             preamble_cycles_o
);
   import dcc_pkg::*;

   logic [`DCC_SYNC_W-1:0] pins_s;
   logic                   cke_s;
   logic                   cs_n_s;
   logic                   act_n_s;
   logic                   term_req_s;
   logic                   bg_s;
   logic [1:0]             ba_s;
   logic [16:0]            addr_s;
   dcc_pwr_t               pwr_d;
   logic                   exec;
   logic                   sre;
   logic                   any_open;
   logic                   is_access;

   dcc_cmd_if cmd ();

   // Every path from a synchronised pin to an output passes at least three register stages, and from a
   // setting input one; each is a single cycle, so no multicycle budget limits the clock rate.
   // single-cycle paths
   dcc_sync #(
      .W       (`DCC_SYNC_W),
      .RST_VAL (`DCC_PIN_RST)
   ) u_sync (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n_i),
      .d_i       ({cke_i, cs_n_i, row_open_cmd_n_i, on_die_term_ctrl_i,
                   bg_i, ba_i, addr_i}),
      .q_o       (pins_s)
   );

   assign {cke_s, cs_n_s, act_n_s, term_req_s, bg_s, ba_s, addr_s} = pins_s;

   // The decoder sees the pins only while the command buffers are on, so a
   // gated buffer cannot leak a stale command into the core.
   dcc_cmd_decode u_dec (
      .en_i    (cmd_buf_en_o),
      .cs_n_i  (cs_n_s),
      .act_n_i (act_n_s),
      .addr_i  (addr_s),
      .bg_i    (bg_s),
      .ba_i    (ba_s),
      .cmd     (cmd.dec)
   );

   // A command with the clock-gate low is an entry request, not an access.
   assign exec      = cmd.valid && cke_s && (pwr_state_o == PS_RUN);
   assign sre       = cmd.valid && (cmd.kind == CMD_REF) && !cke_s;
   assign any_open  = |bank_open_o;
   assign is_access = (cmd.kind == CMD_RD) || (cmd.kind == CMD_WR);

   always_comb begin
      pwr_d = pwr_state_o;
      unique case (pwr_state_o)
         PS_RUN: begin
            if (!cke_s) begin
               if (sre && !any_open) begin
                  pwr_d = PS_SELF_REF;
               end else if (any_open) begin
                  pwr_d = PS_ACT_PD;
               end else begin
                  pwr_d = PS_PRE_PD;
               end
            end
         end
         PS_PRE_PD, PS_ACT_PD: begin
            if (cke_s) begin
               pwr_d = PS_RUN;
            end
         end
         PS_SELF_REF: begin
            if (cke_s) begin
               pwr_d = PS_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         pwr_state_o <= PS_RUN;
      end else begin
         pwr_state_o <= pwr_d;
      end
   end

   // Enables follow the next state so they change with the state itself.
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         int_clk_en_o  <= 1'b1;
         out_drv_en_o  <= 1'b1;
         clk_buf_en_o  <= 1'b1;
         term_buf_en_o <= 1'b1;
         cke_buf_en_o  <= 1'b1;
         cmd_buf_en_o  <= 1'b1;
      end else begin
         int_clk_en_o  <= (pwr_d == PS_RUN);
         out_drv_en_o  <= (pwr_d == PS_RUN);
         clk_buf_en_o  <= (pwr_d != PS_SELF_REF);
         term_buf_en_o <= (pwr_d != PS_SELF_REF);
         cke_buf_en_o  <= 1'b1;
         cmd_buf_en_o  <= (pwr_d == PS_RUN);
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         term_on_o <= 1'b0;
      end else begin
         term_on_o <= term_req_s && term_buf_en_o
                      && !termination_default_dis_i;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         cmd_valid_o  <= 1'b0;
         cmd_kind_o   <= CMD_NONE;
         cmd_bank_o   <= 3'h0;
         row_addr_o   <= 17'h00000;
         auto_close_o <= 1'b0;
         close_all_o  <= 1'b0;
      end else begin
         cmd_valid_o <= exec;
         if (exec) begin
            cmd_kind_o   <= cmd.kind;
            cmd_bank_o   <= cmd.bank;
            row_addr_o   <= cmd.row;
            auto_close_o <= is_access && cmd.auto_close;
            close_all_o  <= (cmd.kind == CMD_PRE) && cmd.auto_close;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         burst_len_o        <= `DCC_BURST_EIGHT;
         burst_interleave_o <= 1'b0;
      end else if (exec && is_access) begin
         unique case (burst_mode_i)
            `DCC_BL_CHOP: burst_len_o <= `DCC_BURST_FOUR;
            `DCC_BL_OTF:  burst_len_o <= cmd.chop_n ? `DCC_BURST_EIGHT
                                                    : `DCC_BURST_FOUR;
            default:      burst_len_o <= `DCC_BURST_EIGHT;
         endcase
         burst_interleave_o <= burst_interleave_i;
      end
   end

   // Banks are marked closed at the auto-close command itself; the actual
   // precharge delay is the array's concern, not this front end's.
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         bank_open_o <= 8'h00;
      end else if (exec) begin
         if (cmd.kind == CMD_ACT) begin
            bank_open_o[cmd.bank] <= 1'b1;
         end else if (cmd.kind == CMD_PRE) begin
            if (cmd.auto_close) begin
               bank_open_o <= 8'h00;
            end else begin
               bank_open_o[cmd.bank] <= 1'b0;
            end
         end else if (is_access && cmd.auto_close) begin
            bank_open_o[cmd.bank] <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         added_delay_o <= 6'h00;
      end else begin
         unique case (added_delay_setting_i)
            `DCC_ADD_RD1: added_delay_o <= read_delay_setting_i - 6'h01;
            `DCC_ADD_RD2: added_delay_o <= read_delay_setting_i - 6'h02;
            default:      added_delay_o <= 6'h00;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         preamble_cycles_o <= `DCC_PRE_ONE;
      end else begin
         preamble_cycles_o <= preamble_two_i ? `DCC_PRE_TWO : `DCC_PRE_ONE;
      end
   end

   act_pd_entry_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (pwr_state_o == PS_RUN && !cke_s && any_open)
      |=> (pwr_state_o == PS_ACT_PD))
      else $error("open bank did not enter active power-down");

   pre_pd_entry_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (pwr_state_o == PS_RUN && !cke_s && !any_open && !sre)
      |=> (pwr_state_o == PS_PRE_PD))
      else $error("idle banks did not enter precharge power-down");

   sr_exit_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (pwr_state_o == PS_SELF_REF && cke_s) |=> (pwr_state_o == PS_RUN))
      else $error("self-refresh exit missed");

   run_clocks_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (int_clk_en_o && out_drv_en_o) == (pwr_state_o == PS_RUN))
      else $error("clock enables disagree with power state");

   pd_buffers_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (pwr_state_o inside {PS_PRE_PD, PS_ACT_PD})
      |-> (!cmd_buf_en_o && clk_buf_en_o && term_buf_en_o && cke_buf_en_o))
      else $error("wrong buffers gated in power-down");

   sr_buffers_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (pwr_state_o == PS_SELF_REF)
      |-> (!cmd_buf_en_o && !clk_buf_en_o && !term_buf_en_o && cke_buf_en_o))
      else $error("wrong buffers gated in self-refresh");

   cs_mask_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      cs_n_s |=> !cmd_valid_o)
      else $error("command taken with chip select high");

   term_apply_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (term_req_s && !termination_default_dis_i && pwr_state_o == PS_RUN)
      |=> term_on_o)
      else $error("termination not applied");

   term_ignore_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      termination_default_dis_i |=> !term_on_o)
      else $error("termination applied while disabled");

   act_open_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (exec && cmd.kind == CMD_ACT)
      |=> (cmd_kind_o == CMD_ACT) && bank_open_o[cmd_bank_o]
          && (row_addr_o == $past(addr_s)))
      else $error("activate did not open the addressed row");

   chop_four_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (exec && is_access && burst_mode_i == `DCC_BL_OTF && !cmd.chop_n)
      |=> (burst_len_o == `DCC_BURST_FOUR))
      else $error("on-the-fly chop ignored");

   added_delay_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (added_delay_setting_i == `DCC_ADD_RD2)
      |=> (added_delay_o == $past(read_delay_setting_i) - 6'h02))
      else $error("added delay not read delay minus two");

   close_all_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (exec && cmd.kind == CMD_PRE && cmd.auto_close)
      |=> (bank_open_o == 8'h00) && close_all_o)
      else $error("precharge of all banks left a bank open");

   access_close_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (exec && is_access && cmd.auto_close)
      |=> auto_close_o && !bank_open_o[cmd_bank_o])
      else $error("auto close did not close the bank");

   chop_mode_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (exec && is_access && burst_mode_i == `DCC_BL_CHOP)
      |=> (burst_len_o == `DCC_BURST_FOUR))
      else $error("fixed chop mode gave a long burst");

   eight_mode_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (exec && is_access && burst_mode_i == `DCC_BL_EIGHT)
      |=> (burst_len_o == `DCC_BURST_EIGHT))
      else $error("fixed eight mode gave a short burst");

   burst_order_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (exec && is_access)
      |=> (burst_interleave_o == $past(burst_interleave_i)))
      else $error("burst ordering not taken");

   gated_no_cmd_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (pwr_state_o != PS_RUN) |=> !cmd_valid_o)
      else $error("command executed while gated");

   preamble_two_a: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      preamble_two_i |=> (preamble_cycles_o == `DCC_PRE_TWO))
      else $error("two-cycle preamble not selected");
endmodule : dcc_cmd_ctrl

//--- verification/dcc_host_model.sv
// Memory controller model that drives the command pins of the front end.
// Assumes one bench thread calls its tasks; each task takes one clock.
`timescale 1ns/1ps
module dcc_host_model (
   input  wire logic        clk_i,
   output logic             cke_o,
   output logic             cs_n_o,
   output logic             act_n_o,
   output logic [16:0]      addr_o,
   output logic             bg_o,
   output logic [1:0]       ba_o
);
   initial begin
      cke_o = 1'b1;
      cs_n_o = 1'b1;
      act_n_o = 1'b1;
      addr_o = 17'h0;
      bg_o = 1'b0;
      ba_o = 2'h0;
   end

   // clock gate moves together with the command pins, selected or not
   task automatic send(input logic cke, cs_n, act_n,
                       input logic [16:0] a, input logic bg,
                       input logic [1:0] ba);
      @(posedge clk_i);
      #1;
      cke_o = cke;
      cs_n_o = cs_n;
      act_n_o = act_n;
      addr_o = a;
      bg_o = bg;
      ba_o = ba;
   endtask : send

   // deselected row-open and address pins do not hold their value
   task automatic idle();
      @(posedge clk_i);
      #1;
      cs_n_o = 1'b1;
      act_n_o = ~act_n_o;
      addr_o = ~addr_o;
   endtask : idle
endmodule : dcc_host_model

//--- verification/tb_dcc_cmd_ctrl.sv
// Self-checking bench for the command front end.
// Assumes the host model drives the pins; notes queue expected commands.
`timescale 1ns/1ps
module tb_dcc_cmd_ctrl;
   import dcc_pkg::*;
   typedef struct {
      dcc_cmd_t k; logic [2:0] b; logic [3:0] bl; logic il;
      logic ac; logic [7:0] bo; int c; logic [16:0] a;
   } dcc_note_t;
   logic clk = 1'b0;
   logic rst_n, term_req, dis, ilv, pre2, cke, cs_n, act_n, bg;
   logic [1:0] ald, bm, ba;
   logic [5:0] rdl;
   logic [16:0] addr;
   logic ice, ode, cbe, tbe, kbe, mbe, ton, vld, acl, cla, bio;
   dcc_pwr_t pws;
   dcc_cmd_t kind;
   logic [2:0] bank;
   logic [16:0] row;
   logic [3:0] blen;
   logic [7:0] bopen, bo = 8'h0;
   logic [5:0] adly;
   logic [1:0] prc;
   logic [31:0] seed = 32'h188, r;
   int failures = 0, checked = 0, cyc = 0;
   dcc_note_t q[$], wn;

   always #20 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;

   dcc_host_model host_inst (.clk_i(clk), .cke_o(cke), .cs_n_o(cs_n),
      .act_n_o(act_n), .addr_o(addr), .bg_o(bg), .ba_o(ba));
   dcc_cmd_ctrl dcc_cmd_ctrl_inst (.ref_clk_i(clk), .rst_n_i(rst_n),
      .cke_i(cke), .cs_n_i(cs_n), .row_open_cmd_n_i(act_n),
      .on_die_term_ctrl_i(term_req), .addr_i(addr), .bg_i(bg), .ba_i(ba),
      .termination_default_dis_i(dis), .added_delay_setting_i(ald),
      .read_delay_setting_i(rdl), .burst_mode_i(bm),
      .burst_interleave_i(ilv), .preamble_two_i(pre2),
      .int_clk_en_o(ice), .out_drv_en_o(ode), .clk_buf_en_o(cbe),
      .term_buf_en_o(tbe), .cke_buf_en_o(kbe), .cmd_buf_en_o(mbe),
      .pwr_state_o(pws), .term_on_o(ton), .cmd_valid_o(vld),
      .cmd_kind_o(kind), .cmd_bank_o(bank), .row_addr_o(row),
      .auto_close_o(acl), .close_all_o(cla), .burst_len_o(blen),
      .burst_interleave_o(bio), .bank_open_o(bopen),
      .added_delay_o(adly), .preamble_cycles_o(prc));

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   task automatic check(input string n, input logic [31:0] s, e);
      checked++;
      if (s !== e) begin
         failures++;
         $display("mismatch %s expected %0h seen %0h", n, e, s);
      end
   endtask : check

   task automatic final_report();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : final_report

   task automatic issue(input logic k, cs, act, input logic [16:0] a,
                        input logic [2:0] bk);
      dcc_note_t n;
      logic [2:0] c;
      c = a[16:14];
      host_inst.send(k, cs, act, a, bk[2], bk[1:0]);
      if (cs === 1'b0 && k === 1'b1 && (act === 1'b0 || c != 3'h7)) begin
         n.k = act ? dcc_cmd_t'({1'b0, c} + 4'h1) : CMD_ACT;
         n.b = bk;
         n.il = ilv;
         n.ac = a[10];
         n.c = cyc + 3;
         n.a = a;
         n.bl = (bm == 2'h1 || (bm == 2'h2 && !a[12])) ? 4'h4 : 4'h8;
         if (!act)
            bo[bk] = 1'b1;
         else if (c == 3'h2)
            bo = a[10] ? 8'h0 : bo & ~(8'h1 << bk);
         else if ((c == 3'h4 || c == 3'h5) && a[10])
            bo[bk] = 1'b0;
         n.bo = bo;
         q.push_back(n);
      end
   endtask : issue

   task automatic drain();
      for (int i = 0; i < 20 && q.size() != 0; i++)
         host_inst.idle();
      host_inst.idle();
      if (q.size() != 0) begin
         failures++;
         final_report();
      end
   endtask : drain

   task automatic pwr_chk(input dcc_pwr_t s, input logic [5:0] en);
      repeat (5) host_inst.idle();
      check("pwr", pws, s);
      check("enables", {ice, ode, cbe, tbe, kbe, mbe}, en);
   endtask : pwr_chk

   always @(negedge clk) begin
      if (vld === 1'b1) begin
         if (q.size() == 0) begin
            check("unexpected", 1, 0);
         end else begin
            wn = q.pop_front();
            check("kind", kind, wn.k);
            check("bank", bank, wn.b);
            check("row", row, wn.a);
            check("open", bopen, wn.bo);
            check("latency", cyc, wn.c);
            if (wn.k == CMD_RD || wn.k == CMD_WR) begin
               check("blen", blen, wn.bl);
               check("ilv", bio, wn.il);
               check("aclose", acl, wn.ac);
            end
            if (wn.k == CMD_PRE)
               check("closeall", cla, wn.ac);
         end
      end
   end

   initial begin
      {rst_n, term_req, dis, ald, bm, ilv, pre2} = '0;
      rdl = 6'h16;
      repeat (8) @(posedge clk);
      #1 rst_n = 1'b1;
      pwr_chk(PS_RUN, 6'h3F);
      check("rst", {blen, prc, adly, bopen, ton}, {4'h8, 2'h1, 15'h0});
      // random command codes under every burst mode
      for (int m = 0; m < 4; m++) begin
         bm = m[1:0];
         ilv = m[0];
         repeat (40) begin
            r = rnd();
            issue(1'b1, r[31:30] == 2'h0, r[29], r[16:0], r[22:20]);
         end
         drain();
      end
      for (int i = 0; i < 4; i++) begin
         r = rnd();
         ald = i[1:0];
         rdl = 6'h2 + {1'b0, r[4:0]};
         pre2 = i[0];
         repeat (3) host_inst.idle();
         check("adly", adly, (i == 1) ? rdl - 6'h1 :
                             (i == 2) ? rdl - 6'h2 : 6'h0);
         check("pre", prc, i[0] ? 2'h2 : 2'h1);
      end
      term_req = 1'b1;
      repeat (5) host_inst.idle();
      check("term", ton, 1'b1);
      dis = 1'b1;
      repeat (3) host_inst.idle();
      check("term_dis", ton, 1'b0);
      dis = 1'b0;
      issue(1'b1, 1'b0, 1'b1, 17'h04000, 3'h0);
      r = rnd();
      issue(1'b1, 1'b0, 1'b0, r[16:0], 3'h5);
      drain();
      host_inst.send(1'b0, 1'b1, 1'b1, r[16:0], 1'b0, 2'h0);
      pwr_chk(PS_ACT_PD, 6'h0E);
      issue(1'b0, 1'b0, 1'b0, r[16:0], 3'h2);
      pwr_chk(PS_ACT_PD, 6'h0E);
      host_inst.send(1'b1, 1'b1, 1'b1, r[16:0], 1'b0, 2'h0);
      pwr_chk(PS_RUN, 6'h3F);
      issue(1'b1, 1'b0, 1'b1, 17'h08400, 3'h1);
      drain();
      issue(1'b0, 1'b0, 1'b1, 17'h04000, 3'h0);
      pwr_chk(PS_SELF_REF, 6'h02);
      check("term_sr", ton, 1'b0);
      r = rnd();
      host_inst.send(1'b1, 1'b1, 1'b1, r[16:0], 1'b0, 2'h0);
      pwr_chk(PS_RUN, 6'h3F);
      host_inst.send(1'b0, 1'b1, 1'b1, r[16:0], 1'b0, 2'h0);
      pwr_chk(PS_PRE_PD, 6'h0E);
      host_inst.send(1'b1, 1'b1, 1'b1, r[16:0], 1'b0, 2'h0);
      pwr_chk(PS_RUN, 6'h3F);
      final_report();
   end
endmodule : tb_dcc_cmd_ctrl
